// [logic/ryp_pkg.sv]
// Package for the RGB to 4:2:2 packer: formats, coefficients, limits
package ryp_pkg;
  // Output format select
  localparam logic [1:0] FMT_STANDARD = 2'h0; // U Y V Y
  localparam logic [1:0] FMT_GRABBER  = 2'h1; // Y U Y V
  localparam logic [1:0] FMT_MONO     = 2'h2; // Y only
  // Coefficients in units of 1/256 (0.30*256 etc, nearest)
  localparam int COEF_SHIFT = 8;
  localparam int KY_R = 77;   // 0.30
  localparam int KY_G = 151;  // 0.59
  localparam int KY_B = 28;   // 0.11
  localparam int KU_R = -44;  // -0.17
  localparam int KU_G = -84;  // -0.33
  localparam int KU_B = 128;  // 0.50
  localparam int KV_R = 128;  // 0.50
  localparam int KV_G = -105; // -0.41
  localparam int KV_B = -23;  // -0.09
  localparam int ROUND_HALF = 128;
  // Ranges
  localparam int LUMA_MAX   = 255;
  localparam int CHROMA_MIN = -128;
  localparam int CHROMA_MAX = 127;
  localparam logic [7:0] CHROMA_OFFSET = 8'h80; // Adds 128
  // Debayer tile: 2x2 BG mosaic, even row B G, odd row G R
  localparam int TILE_PIXELS = 4;
  // Index of the last output byte slot per pixel pair
  localparam logic [1:0] LAST_SLOT = 2'h3;
  // Pipeline depth of the converter, in cycles
  localparam int CONV_LATENCY = 1;
  // Packer output state
  typedef enum logic [1:0] {RYP_IDLE, RYP_SEND} ryp_state_t;
endpackage

// [logic/ryp_convert.sv]
// Registered RGB to Y U V converter with rounding and saturation
`timescale 1ns/1ns
module ryp_convert
  import ryp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Input pixel
  input  wire logic       inValid,
  input  wire logic [7:0] red,
  input  wire logic [7:0] green,
  input  wire logic [7:0] blue,
  // Converted pixel, one cycle later
  output logic            outValid,
  output logic [7:0]      luma,
  output logic [7:0]      chromaB,
  output logic [7:0]      chromaR
);
  // Weighted sum, rounded to nearest in 1/256 units
  function automatic int wsum(input int kr, input int kg, input int kb,
                              input logic [7:0] r, input logic [7:0] g,
                              input logic [7:0] b);
    int acc;
    acc = kr * int'(r) + kg * int'(g) + kb * int'(b) + ROUND_HALF;
    return acc >>> COEF_SHIFT;
  endfunction

  // Clamp into a range
  function automatic int clampv(input int v, input int lo, input int hi);
    int res;
    res = (v < lo) ? lo : ((v > hi) ? hi : v);
    return res;
  endfunction

  int yv;  // Luma after clamp
  int uv;  // Blue difference after clamp
  int vv;  // Red difference after clamp
  always_comb begin
    yv = clampv(wsum(KY_R, KY_G, KY_B, red, green, blue), 0, LUMA_MAX);
    uv = clampv(wsum(KU_R, KU_G, KU_B, red, green, blue),
                CHROMA_MIN, CHROMA_MAX);
    vv = clampv(wsum(KV_R, KV_G, KV_B, red, green, blue),
                CHROMA_MIN, CHROMA_MAX);
  end

  // Output register; offset binary by flipping sign after clamp
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outValid <= 1'b0;
      luma     <= 8'h00;
      chromaB  <= 8'h80;
      chromaR  <= 8'h80;
    end else begin
      outValid <= inValid;
      luma     <= 8'(yv);
      chromaB  <= 8'(uv) + CHROMA_OFFSET;
      chromaR  <= 8'(vv) + CHROMA_OFFSET;
    end
  end

  // Grey input gives neutral blue difference code 0x80
  a_chroma_zero: assert property (@(posedge mclk) disable iff (!nrst)
    (inValid && red == green && green == blue) |=> chromaB == 8'h80)
    else $error("grey input did not give neutral chroma");
endmodule

// [logic/ryp_packer.sv]
// Top: 2x2 demosaic, colour conversion, 4:2:2 or mono byte packing
`timescale 1ns/1ns
// Contract
// - Rebuild full RGB from mosaic first
// - Luma is 0.30R + 0.59G + 0.11B
// - Blue difference -0.17R -0.33G +0.50B
// - Red difference 0.50R -0.41G -0.09B
// - Add 128 to every chroma value
// - Limit chroma to -128..+127 before offset
// - Luma is unsigned byte 0..255
// - Chroma is offset binary, 0x80 is zero
// - Chroma once per pair, from even pixel
// - Standard order: U, Y0, V, Y1
// - Grabber order: Y0, U, Y1, V
// - Formats differ only in byte placement; the mono format sends luma bytes alone, with no chroma
// - Send bytes only after conversion completes
// - Bytes leave in pixel transmission order
// - Mono output: one luma byte per pixel
module ryp_packer
  import ryp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Configuration, held stable within a frame
  input  wire logic [1:0] format,
  // Mosaic sample stream: a 2x2 tile B G / G R per beat
  input  wire logic       tileValid,
  output logic            tileReady,
  input  wire logic [7:0] sampB,
  input  wire logic [7:0] sampG0,
  input  wire logic [7:0] sampG1,
  input  wire logic [7:0] sampR,
  input  wire logic       tileFirst,
  // Byte stream toward the transmit path
  output logic            byteValid,
  input  wire logic       byteReady,
  output logic [7:0]      byteData,
  output logic            byteFirst
);
  import ryp_pkg::*;

  // Demosaiced pixel: each tile gives one full-colour pixel
  logic [8:0] greenSum; // Sum of both greens
  logic [7:0] pixR;
  logic [7:0] pixG;
  logic [7:0] pixB;
  logic       convIn;   // Pixel accepted into converter
  logic       cValid;
  logic [7:0] cY;
  logic [7:0] cU;
  logic [7:0] cV;

  // Simple demosaic: greens averaged, red and blue taken as is
  always_comb begin
    greenSum = {1'b0, sampG0} + {1'b0, sampG1};
    pixG     = greenSum[8:1];
    pixR     = sampR;
    pixB     = sampB;
  end

  // Accept a tile only while the packer is free for a new pixel
  assign convIn = tileValid && tileReady;

  ryp_convert u_conv (
    .mclk     (mclk),
    .nrst     (nrst),
    .inValid  (convIn),
    .red      (pixR),
    .green    (pixG),
    .blue     (pixB),
    .outValid (cValid),
    .luma     (cY),
    .chromaB  (cU),
    .chromaR  (cV)
  );

  // Packer state
  ryp_state_t state;
  logic       oddPix;    // Next converted pixel is odd in its pair
  logic [7:0] evenY;     // Held even pixel luma
  logic [7:0] evenU;     // Held even pixel chroma, shared by the pair
  logic [7:0] evenV;
  logic [7:0] oddY;
  logic [1:0] slot;      // Byte slot within a four-byte group
  logic       firstPend; // Frame start seen, not yet emitted
  logic       busy;      // Conversion in flight or group being sent
  logic       inFlight;

  // Byte selector for a slot; only placement differs by format
  function automatic logic [7:0] pick(input logic [1:0] fmt,
                                      input logic [1:0] s,
                                      input logic [7:0] y0,
                                      input logic [7:0] u,
                                      input logic [7:0] v,
                                      input logic [7:0] y1);
    logic [7:0] b;
    b = y0;
    if (fmt == FMT_GRABBER) begin
      case (s)
        2'h0:    b = y0;
        2'h1:    b = u;
        2'h2:    b = y1;
        default: b = v;
      endcase
    end else begin
      case (s)
        2'h0:    b = u;
        2'h1:    b = y0;
        2'h2:    b = v;
        default: b = y1;
      endcase
    end
    return b;
  endfunction

  // One pixel at a time: no new tile while a group is in flight.
  // Costs throughput but keeps the design free of buffering.
  assign busy      = inFlight || (state == RYP_SEND);
  assign tileReady = !busy;

  // Converter occupancy tracker
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      inFlight <= 1'b0;
    end else begin
      inFlight <= convIn;
    end
  end

  // Frame start marker follows its pixel to the first output byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      firstPend <= 1'b0;
    end else if (convIn && tileFirst) begin
      firstPend <= 1'b1;
    end else if (byteValid && byteReady && byteFirst) begin
      firstPend <= 1'b0;
    end
  end

  // Pair capture: hold even pixel's chroma, drop odd pixel's chroma
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      oddPix <= 1'b0;
      evenY  <= 8'h00;
      evenU  <= 8'h80;
      evenV  <= 8'h80;
      oddY   <= 8'h00;
    end else if (convIn && tileFirst) begin
      oddPix <= 1'b0; // Frame start realigns pairing
    end else if (cValid && format != FMT_MONO) begin
      if (!oddPix) begin
        evenY <= cY;
        evenU <= cU;
        evenV <= cV;
      end else begin
        oddY <= cY;
      end
      oddPix <= !oddPix;
    end else if (cValid) begin
      evenY <= cY;
    end
  end

  // Send control: group starts only once conversion completes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= RYP_IDLE;
      slot  <= 2'h0;
    end else begin
      case (state)
        RYP_IDLE: begin
          if (cValid && (format == FMT_MONO || oddPix)) begin
            state <= RYP_SEND;
            slot  <= 2'h0;
          end
        end
        RYP_SEND: begin
          if (byteReady) begin
            if (format == FMT_MONO || slot == LAST_SLOT) begin
              state <= RYP_IDLE;
            end else begin
              slot <= slot + 2'h1;
            end
          end
        end
        default: state <= RYP_IDLE;
      endcase
    end
  end

  // Registered byte output, held under back-pressure
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      byteValid <= 1'b0;
      byteData  <= 8'h00;
      byteFirst <= 1'b0;
    end else if (state == RYP_IDLE && cValid && format == FMT_MONO) begin
      byteValid <= 1'b1;
      byteData  <= cY;
      byteFirst <= firstPend;
    end else if (state == RYP_IDLE && cValid && oddPix) begin
      byteValid <= 1'b1;
      byteData  <= pick(format, 2'h0, evenY, evenU, evenV, cY);
      byteFirst <= firstPend;
    end else if (state == RYP_SEND && byteReady) begin
      if (format == FMT_MONO || slot == LAST_SLOT) begin
        byteValid <= 1'b0;
      end else begin
        byteData  <= pick(format, slot + 2'h1, evenY, evenU, evenV, oddY);
        byteFirst <= 1'b0;
      end
    end
  end

  // Bytes appear only after a converter result
  a_send_after: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(byteValid) |-> $past(cValid))
    else $error("byte sent before conversion done");

  // A standard-order group starts with the held chroma
  a_std_first: assert property (@(posedge mclk) disable iff (!nrst)
    ($rose(byteValid) && format == FMT_STANDARD) |-> byteData == evenU)
    else $error("standard group not led by blue difference");

  // A grabber-order group starts with even luma
  a_grab_first: assert property (@(posedge mclk) disable iff (!nrst)
    ($rose(byteValid) && format == FMT_GRABBER) |-> byteData == evenY)
    else $error("grabber group not led by even luma");

  // Mono sends a single byte per pixel
  a_mono_one: assert property (@(posedge mclk) disable iff (!nrst)
    (byteValid && byteReady && format == FMT_MONO) |=> !byteValid)
    else $error("mono pixel gave more than one byte");

  // No input taken while a group is pending
  a_no_overrun: assert property (@(posedge mclk) disable iff (!nrst)
    (state == RYP_SEND) |-> !tileReady)
    else $error("tile accepted during send");

  // Chroma held only from even pixel
  a_even_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (cValid && oddPix && format != FMT_MONO) |=> $stable(evenU))
    else $error("odd pixel chroma overwrote pair chroma");

  // Frame mark only while a frame start is pending
  a_first_mark: assert property (@(posedge mclk) disable iff (!nrst)
    (byteValid && byteFirst) |-> firstPend)
    else $error("first-byte mark without a pending frame start");
endmodule

// [test/ryp_sink.sv]
// Byte sink standing in for the transmit path, with optional stalls
`timescale 1ns/1ns
module ryp_sink (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Byte stream from the packer
  input  wire logic       byteValid,
  input  wire logic [7:0] byteData,
  input  wire logic       byteFirst,
  output logic            byteReady,
  // Stall request from the bench
  input  wire logic       stall
);
  logic [8:0] got[$]; // Accepted bytes, first flag in bit 8

  // Ready toggles while stalling, so each byte must be held across gaps
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      byteReady <= 1'b0;
    end else begin
      byteReady <= stall ? ~byteReady : 1'b1;
    end
  end

  // Record a byte only at the edge where it is really taken
  always @(posedge mclk) begin
    if (nrst && byteValid && byteReady) begin
      got.push_back({byteFirst, byteData});
    end
  end
endmodule

// [test/tb_top.sv]
// Self-checking bench for the RGB to 4:2:2 packer
`timescale 1ns/1ns
module tb_top;
  import ryp_pkg::*;
  logic       mclk      = 1'b0;  // 100 MHz pixel clock
  logic       nrst      = 1'b0;  // Async reset, active low
  logic [1:0] format    = 2'h0;  // Output format select
  logic       tileValid = 1'b0;  // Tile offered
  logic [7:0] sampB     = 8'h00; // Mosaic samples
  logic [7:0] sampG     = 8'h00; // Both greens equal, average is exact
  logic [7:0] sampR     = 8'h00;
  logic       tileFirst = 1'b0;  // First pixel of frame
  logic       stall     = 1'b0;  // Sink stalls when set
  logic       tileReady, byteValid, byteReady, byteFirst;
  logic [7:0] byteData;
  int         miscompares = 0;
  int         n_checks    = 0;

  // Clock generator
  always #5 mclk = ~mclk;

  ryp_packer dut (.mclk(mclk), .nrst(nrst), .format(format),
    .tileValid(tileValid), .tileReady(tileReady), .sampB(sampB),
    .sampG0(sampG), .sampG1(sampG), .sampR(sampR), .tileFirst(tileFirst),
    .byteValid(byteValid), .byteReady(byteReady), .byteData(byteData),
    .byteFirst(byteFirst));

  ryp_sink snk (.mclk(mclk), .nrst(nrst), .byteValid(byteValid),
    .byteData(byteData), .byteFirst(byteFirst), .byteReady(byteReady),
    .stall(stall));

  // Rounded, clamped, offset colour component from a {R,G,B} pixel
  function automatic logic [7:0] conv(input int kr, kg, kb,
      input logic [23:0] p, input int lo, hi, off);
    int s;
    s = (kr * int'(p[23:16]) + kg * int'(p[15:8]) + kb * int'(p[7:0])
         + ROUND_HALF) >>> COEF_SHIFT;
    if (s < lo) s = lo;
    if (s > hi) s = hi;
    return 8'(s + off);
  endfunction

  task automatic chk_byte(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask

  // Offer one tile and hold it until the edge that takes it
  task automatic send_tile(input logic [23:0] p, input logic f);
    int n;
    n = 0;
    @(posedge mclk);
    tileValid <= 1'b1;
    sampR <= p[23:16];
    sampG <= p[15:8];
    sampB <= p[7:0];
    tileFirst <= f;
    @(negedge mclk);
    while (tileReady !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    tileValid <= 1'b0;
  endtask

  // Send a frame, then judge every byte against the modelled stream
  task automatic run_frame(input string nm, input logic [1:0] fmt,
      input logic [23:0] px[$], input bit slow);
    logic [7:0] ex[$];
    logic [7:0] y0, u, v, y1;
    int n;
    snk.got.delete();
    format <= fmt;
    stall <= slow;
    foreach (px[i]) begin
      y1 = conv(KY_R, KY_G, KY_B, px[i], 0, LUMA_MAX, 0);
      if (fmt == FMT_MONO) ex.push_back(y1);
      else if (i % 2 == 0) begin
        y0 = y1;
        u = conv(KU_R, KU_G, KU_B, px[i], CHROMA_MIN, CHROMA_MAX, 128);
        v = conv(KV_R, KV_G, KV_B, px[i], CHROMA_MIN, CHROMA_MAX, 128);
      end
      else if (fmt == FMT_STANDARD) ex = {ex, u, y0, v, y1};
      else ex = {ex, y0, u, y1, v};
    end
    foreach (px[i]) send_tile(px[i], i == 0);
    n = 0;
    while (snk.got.size() < ex.size() && n < 400) begin
      @(posedge mclk);
      n++;
    end
    repeat (10) @(posedge mclk);
    chk_byte({nm, " count"}, 8'(ex.size()), 8'(snk.got.size()));
    foreach (ex[i]) begin
      chk_byte({nm, " byte"}, ex[i], snk.got[i][7:0]);
      chk_bit({nm, " first"}, i == 0, snk.got[i][8]);
    end
    $display("test %s done", nm);
  endtask

  // Two pairs back to back, full speed
  task automatic test_standard();
    run_frame("standard", FMT_STANDARD,
      {24'h204060, 24'hC08010, 24'h10F0A0, 24'h808080}, 0);
  endtask

  // Same pixels with a stalling sink, only byte placement differs
  task automatic test_grabber();
    run_frame("grabber", FMT_GRABBER,
      {24'h204060, 24'hC08010, 24'h10F0A0, 24'h808080}, 1);
  endtask

  // Luma only, bounds of the luma range included
  task automatic test_mono();
    run_frame("mono", FMT_MONO,
      {24'hFFFFFF, 24'h000000, 24'h3399CC}, 1);
  endtask

  // Blue and red chroma saturated at 0xFF; white sent only as odd luma, its chroma dropped
  task automatic test_limits();
    run_frame("limits", FMT_STANDARD, {24'h0000FF, 24'hFF0000,
      24'hFF0000, 24'h0000FF, 24'h00FF00, 24'hFFFFFF}, 0);
  endtask

  // A trailing unpaired pixel sends nothing
  task automatic test_unpaired();
    run_frame("unpaired", FMT_GRABBER,
      {24'h405060, 24'h708090, 24'hA0B0C0}, 0);
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    test_standard();
    test_grabber();
    test_mono();
    test_limits();
    test_unpaired();
    finish_test();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule
